/* File: rtl/uart_rx.v */
/*
 Asynchronous receive path: start detection, three-sample voting,
 parity and stop checks, two-deep receive queue, register port.
 Assumes rx_pin already synchronous to clock; one system clock.
*/
// Operation
// - Parity is checked only while the parity enable bit is one
// - Parity odd select bit chooses odd or even checking
// - Parity outcome stored in the queue beside data and stop status
// - Visible parity error describes oldest unread entry until data read
// - Clearing receiver enable abandons the frame in progress at once
// - Disabled receiver releases its hold on the receive pin
// - Disabling the receiver empties the queue with its status
// - Receive complete is one exactly while the queue holds data
// - Queue holds two; overrun when full, one waiting, new start seen
// - Sixteen samples per bit normally, eight in double speed
// - Falling edge of idle line starts detection; first low is sample one
// - Start checked on samples 8,9,10 or 4,5,6; two highs reject it
// - Sample phase realigned to every accepted start bit
// - Per-bit state sequence of sixteen or eight states
// - Each bit decided by majority of three centre samples
// - Middle vote sample is 9 or 5, first one position earlier
// - Frame received through first stop bit; later stop bits ignored
// - First stop voted; zero sets frame error for that frame
// - Next start edge accepted right after the stop decision sample
`timescale 1ns/1ps
`include "uart_rx_regs.vh"

module uart_rx #(
   parameter DATA_W = 8
) (
   input  wire        clock,
   input  wire        rst,
   input  wire [3:0]  addr,
   input  wire [7:0]  wdata,
   input  wire        wr,
   input  wire        rd,
   input  wire        rx_pin,
   output reg  [7:0]  rdata,
   output reg         rx_override,
   output reg         receive_complete_flag
);

   localparam S_IDLE  = 3'b001;
   localparam S_START = 3'b010;
   localparam S_BITS  = 3'b100;

   reg  [7:0]  ctrl_q;
   reg  [15:0] baud_divisor_value;
   reg  [15:0] div_cnt_q;
   reg         tick;
   reg  [2:0]  state_q;
   reg  [4:0]  samp_q;
   reg  [3:0]  bit_q;
   reg  [2:0]  vote_q;
   reg  [8:0]  shift_q;
   reg         prev_q;
   reg         par_q;
   reg         hold_q;
   reg  [7:0]  hold_data_q;
   reg  [2:0]  hold_st_q;
   reg  [7:0]  fifo_data [0:1];
   reg  [2:0]  fifo_st   [0:1];
   reg  [1:0]  count_q;
   reg         rd_ptr_q;
   reg         wr_ptr_q;

   wire        receiver_enable_bit = ctrl_q[`CTRL_RX_EN];
   wire        double_speed_select = ctrl_q[`CTRL_DBL];
   wire        parity_odd_select   = ctrl_q[`CTRL_PAR_ODD];
   wire        parity_enable_bit   = ctrl_q[`CTRL_PAR_EN];
   wire [1:0]  size_sel = ctrl_q[`CTRL_BITS_HI:`CTRL_BITS_LO];
   wire [3:0]  nbits    = 4'h5 + {2'b00, size_sel};
   wire [4:0]  spb   = double_speed_select ? `SPB_DOUBLE :
                       `SPB_NORMAL;
   wire [4:0]  first = double_speed_select ? `VOTE_DOUBLE : `VOTE_NORMAL;
   wire [3:0]  last_bit = nbits + {3'b000, parity_enable_bit};
   wire        fifo_full  = (count_q == `FIFO_DEPTH);
   wire        fifo_empty = (count_q == 2'h0);
   wire        pop = rd && (addr == `ADDR_DATA) && !fifo_empty;

   function maj3;
      input [2:0] v;
      begin
         maj3 = (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
      end
   endfunction

   // Three centre samples, one either side of the middle
   function in_vote;
      input [4:0] s;
      input [4:0] f;
      begin
         in_vote = (s == f - 5'h01) || (s == f) || (s == f + 5'h01);
      end
   endfunction

   // Mask bits above the chosen character size
   function [7:0] mask_data;
      input [8:0] s;
      input [3:0] n;
      integer     k;
      begin
         mask_data = 8'h00;
         for (k = 0; k < 8; k = k + 1) begin
            if (k < n) begin
               mask_data[k] = s[k];
            end
         end
      end
   endfunction

   // Bits above the character size read as zero
   wire [7:0] rx_data = mask_data(shift_q, nbits);
   wire       rx_par  = shift_q[nbits];
   wire       data_par = ^rx_data;
   // Even: data xor parity bit must be zero; odd: one
   wire       par_odd = (data_par ^ rx_par);
   wire       par_bad = parity_enable_bit &&
                        (par_odd != parity_odd_select);
   // Tick after the last vote sample: all three votes are in
   wire       decide  = (samp_q == first + 5'h02);
   wire       frame_done = (state_q == S_BITS) && tick &&
                           (bit_q == last_bit) && decide;
   wire       start_edge = prev_q && !rx_pin;
   // A loss needs both slots, the hold stage and a fresh start
   wire       overrun_hit = (state_q == S_IDLE) && tick && start_edge &&
                            fifo_full && hold_q;
   // Hold moves in when a slot is free or being freed by a read
   wire       move_in = hold_q && !frame_done && (!fifo_full || pop);
   wire [1:0] count_d = count_q + {1'b0, move_in} - {1'b0, pop};

   // Baud tick at sixteen or eight times the bit rate
   // Divider parked while disabled: first tick divisor+1 clocks after enable
   always @(posedge clock) begin
      if (rst || !receiver_enable_bit) begin
         div_cnt_q <= `DIV_RESET;
         tick <= 1'b0;
      end else if (div_cnt_q == baud_divisor_value) begin
         div_cnt_q <= `DIV_RESET;
         tick <= 1'b1;
      end else begin
         div_cnt_q <= div_cnt_q + 16'h0001;
         tick <= 1'b0;
      end
   end

   // Register writes
   always @(posedge clock) begin
      if (rst) begin
         ctrl_q <= `CTRL_RESET;
         baud_divisor_value <= `DIV_RESET;
      end else if (wr) begin
         if (addr == `ADDR_CTRL) begin
            ctrl_q <= wdata;
         end
         if (addr == `ADDR_DIVISOR) begin
            baud_divisor_value <= {8'h00, wdata};
         end
      end
   end

   // Receive state machine
   always @(posedge clock) begin
      if (rst || !receiver_enable_bit) begin
         // Unlike sending, nothing in flight is finished
         state_q <= S_IDLE;
         samp_q <= 5'h00;
         bit_q <= 4'h0;
         vote_q <= 3'b000;
         shift_q <= 9'h000;
         prev_q <= 1'b0;
      end else if (tick) begin
         prev_q <= rx_pin;
         case (state_q)
            S_IDLE: begin
               if (start_edge) begin
                  state_q <= S_START;
                  samp_q <= 5'h01;
               end
            end
            S_START: begin
               samp_q <= samp_q + 5'h01;
               if (in_vote(samp_q, first)) begin
                  vote_q <= {vote_q[1:0], rx_pin};
               end
               // Rejected start: wait for the line to go high again
               if (decide) begin
                  if (maj3(vote_q)) begin
                     state_q <= S_IDLE;
                     prev_q <= 1'b0;
                  end else begin
                     // Phase now tied to this start bit
                     state_q <= S_BITS;
                     samp_q <= first + 5'h03;
                     bit_q <= 4'h0;
                  end
               end
            end
            S_BITS: begin
               // Samples wrap at spb: one state per sample
               if (samp_q == spb) begin
                  samp_q <= 5'h01;
               end else begin
                  samp_q <= samp_q + 5'h01;
               end
               if (in_vote(samp_q, first)) begin
                  vote_q <= {vote_q[1:0], rx_pin};
               end
               if (decide) begin
                  if (bit_q == last_bit) begin
                     // Idle at once so next edge is caught early
                     state_q <= S_IDLE;
                     prev_q <= rx_pin;
                  end else begin
                     shift_q[bit_q] <= maj3(vote_q);
                     bit_q <= bit_q + 4'h1;
                  end
               end
            end
            default: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end

   // Vote window uses samples first-1..first+1, checked at first+2
   wire stop_frame_err = !maj3(vote_q);

   // Queue, hold stage and overrun
   always @(posedge clock) begin
      if (rst || !receiver_enable_bit) begin
         // Every unread entry goes, status included
         count_q <= 2'h0;
         rd_ptr_q <= 1'b0;
         wr_ptr_q <= 1'b0;
         hold_q <= 1'b0;
         hold_data_q <= 8'h00;
         hold_st_q <= 3'b000;
         par_q <= 1'b0;
      end else begin
         // Flag rides on the entry that follows the loss
         if (overrun_hit) begin
            par_q <= 1'b1;
         end
         if (frame_done) begin
            hold_q <= 1'b1;
            hold_data_q <= rx_data;
            // Status: frame, overrun, parity
            hold_st_q <= {stop_frame_err, 1'b0, par_bad};
         end else if (hold_q && (!fifo_full || pop)) begin
            fifo_data[wr_ptr_q] <= hold_data_q;
            fifo_st[wr_ptr_q] <= {hold_st_q[2], par_q, hold_st_q[0]};
            wr_ptr_q <= ~wr_ptr_q;
            hold_q <= 1'b0;
            par_q <= 1'b0;
         end
         if (pop) begin
            rd_ptr_q <= ~rd_ptr_q;
         end
         count_q <= count_d;
      end
   end

   // Read port and flop-driven outputs
   always @(posedge clock) begin
      if (rst) begin
         rdata <= 8'h00;
         rx_override <= 1'b0;
         receive_complete_flag <= 1'b0;
      end else begin
         // Pin back to its port function while disabled
         rx_override <= receiver_enable_bit;
         // Next count, so the flag drops with the last read
         receive_complete_flag <= receiver_enable_bit &&
                                  (count_d != 2'h0);
         rdata <= 8'h00;
         if (rd) begin
            case (addr)
               `ADDR_DATA: rdata <= fifo_empty ? 8'h00 :
                                    fifo_data[rd_ptr_q];
               `ADDR_STATUS: begin
                  rdata[`ST_RX_DONE] <= !fifo_empty;
                  rdata[`ST_DBL] <= double_speed_select;
                  if (!fifo_empty) begin
                     rdata[`ST_FRAME_ERR] <= fifo_st[rd_ptr_q][2];
                     rdata[`ST_OVERRUN] <= fifo_st[rd_ptr_q][1];
                     rdata[`ST_PAR_ERR] <= fifo_st[rd_ptr_q][0];
                  end
               end
               `ADDR_CTRL: rdata <= ctrl_q;
               `ADDR_DIVISOR: rdata <= baud_divisor_value[7:0];
               default: rdata <= 8'h00;
            endcase
         end
      end
   end

endmodule // uart_rx

/* File: rtl/uart_rx_regs.vh */
/*
 Register offsets, field positions and timing constants of the
 asynchronous receive path. Assumes inclusion by the receiver module.
*/
`ifndef UART_RX_REGS_VH
`define UART_RX_REGS_VH

`define ADDR_DATA      4'h0
`define ADDR_STATUS    4'h1
`define ADDR_CTRL      4'h2
`define ADDR_DIVISOR   4'h3

`define CTRL_RX_EN     0
`define CTRL_DBL       1
`define CTRL_PAR_ODD   2
`define CTRL_PAR_EN    3
`define CTRL_BITS_LO   4
`define CTRL_BITS_HI   5

`define ST_RX_DONE     7
`define ST_FRAME_ERR   4
`define ST_OVERRUN     3
`define ST_PAR_ERR     2
`define ST_DBL         1

`define CTRL_RESET     8'h00
`define DIV_RESET      16'h0000

`define SPB_NORMAL     5'h10
`define SPB_DOUBLE     5'h08
`define VOTE_NORMAL    5'h08
`define VOTE_DOUBLE    5'h04
`define FIFO_DEPTH     2'h2

`endif

/* File: testbench/rx_checker.sv */
/* Port assertions for the receive path.
 Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`include "uart_rx_regs.vh"
module rx_checker (
   input wire       clock,
   input wire       rst,
   input wire [3:0] addr,
   input wire [7:0] wdata,
   input wire       wr,
   input wire       rd,
   input wire       rx_pin,
   input wire [7:0] rdata,
   input wire       rx_override,
   input wire       receive_complete_flag
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   wire ctl_w = wr && addr == `ADDR_CTRL;
   reset_clear_a: assert property ($fell(rst) |-> !rx_override &&
      !receive_complete_flag && rdata == 8'h00) else $error("reset state");
   enable_takes_a: assert property (ctl_w && wdata[0] |->
      ##[1:2] rx_override) else $error("override not taken");
   disable_frees_a: assert property (ctl_w && !wdata[0] |->
      ##[1:2] !rx_override) else $error("override not released");
   disable_flush_a: assert property (ctl_w && !wdata[0] |->
      ##[1:3] !receive_complete_flag) else $error("queue not flushed");
   idle_no_data_a: assert property (!rx_override &&
      !receive_complete_flag |=> !receive_complete_flag)
      else $error("data while disabled");
   frame_time_a: assert property ($rose(receive_complete_flag) |->
      $past(rx_override, 40)) else $error("frame too short");
   rdata_quiet_a: assert property (!$past(rd) |->
      rdata == 8'h00) else $error("read data not zero");
   status_done_a: assert property (rd && addr == `ADDR_STATUS &&
      receive_complete_flag && !$past(rd) && !$past(wr) && !$past(wr, 2)
      |=> rdata[`ST_RX_DONE]) else $error("status done bit low");
   cover property ($rose(receive_complete_flag));
   cover property (rd && addr == `ADDR_STATUS ##1 rdata[`ST_PAR_ERR]);
   cover property ($fell(rx_override));
   cover property (rd && addr == `ADDR_STATUS ##1 rdata[`ST_OVERRUN]);
endmodule // rx_checker
bind uart_rx rx_checker chk (.clock(clock), .rst(rst), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rx_pin(rx_pin), .rdata(rdata),
   .rx_override(rx_override), .receive_complete_flag(receive_complete_flag));

/* File: testbench/serial_source.sv */
/* Remote serial transmitter model driving the receive line.
 Assumes calls are made just after a rising clock edge. */
`timescale 1ns/1ps
module serial_source (
   input  wire clock,
   output reg  line
);
   initial line = 1'b1;
   // LSB first, n clocks per bit; the last bit lasts ns clocks
   task automatic send(input [7:0] d, input [1:0] par, input stp,
                       input integer n, input integer ns);
      reg [10:0] f;
      integer    i;
      integer    k;
      begin
         f = par[1] ? {stp, par[0], d, 1'b0} : {1'b1, stp, d, 1'b0};
         k = par[1] ? 11 : 10;
         for (i = 0; i < k; i = i + 1) begin
            line <= f[i];
            repeat (i == k - 1 ? ns : n) @(posedge clock);
         end
         if (!stp)
            line <= 1'b1;
      end
   endtask
   // Short low spike, too brief to pass the start vote
   task automatic pulse(input integer n);
      begin
         line <= 1'b0;
         repeat (n) @(posedge clock);
         line <= 1'b1;
      end
   endtask
endmodule // serial_source

/* File: testbench/tb.sv */
/* Self-checking bench for the receive path.
 Assumes the serial source model; divisor 1 gives a tick every 2 clocks. */
`timescale 1ns/1ps
`include "uart_rx_regs.vh"
module tb;
   reg        clock = 1'b0;
   reg        rst = 1'b1;
   reg  [3:0] addr = 4'h0;
   reg  [7:0] wdata = 8'h00;
   reg        wr = 1'b0;
   reg        rd = 1'b0;
   wire       line;
   wire [7:0] rdata;
   wire       ovr;
   wire       rcf;
   reg  [7:0] c;
   reg  [7:0] v;
   integer    n_errors = 0;
   integer    check_count = 0;
   integer    i;
   always #10 clock = ~clock;
   uart_rx dut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rx_pin(line), .rdata(rdata), .rx_override(ovr),
      .receive_complete_flag(rcf));
   serial_source src (.clock(clock), .line(line));
   task stop_test;
      begin
         $display("Checks %0d mismatches %0d", check_count, n_errors);
         if (n_errors == 0 && check_count > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   task chk(input string nm, input [7:0] e, input [7:0] g);
      begin
         check_count = check_count + 1;
         if (g !== e) begin
            n_errors = n_errors + 1;
            $display("Error %s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   // One bus cycle; a read leaves its data in c
   task bus(input w, input [3:0] a, input [7:0] d);
      begin
         @(posedge clock);
         addr <= a;
         wdata <= d;
         wr <= w;
         rd <= !w;
         @(posedge clock);
         wr <= 1'b0;
         rd <= 1'b0;
         #1 c = rdata;
      end
   endtask
   task rx_chk(input [7:0] d, input [7:0] st);
      integer k;
      begin
         for (k = 0; k < 3000 && rcf !== 1'b1; k = k + 1) begin
            @(posedge clock);
            #1;
         end
         if (k == 3000) begin
            chk("rx_wait", 8'h01, 8'h00);
            stop_test;
         end
         bus(1'b0, `ADDR_STATUS, 8'h00);
         chk("status", st, c & 8'h9e);
         bus(1'b0, `ADDR_DATA, 8'h00);
         chk("data", d, c);
      end
   endtask
   initial begin
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      #1 chk("reset", 8'h00, {6'h00, ovr, rcf});
      bus(1'b0, `ADDR_CTRL, 8'h00);
      chk("ctrl", `CTRL_RESET, c);
      bus(1'b1, `ADDR_DIVISOR, 8'h01);
      for (i = 0; i < 16; i = i + 1) begin
         v = {4'h3, i[3:0]};
         bus(1'b1, `ADDR_CTRL, {4'h3, i[2], i[1], i[3], 1'b1});
         repeat (8) @(posedge clock);
         src.send(v, {i[2], i[0]}, 1'b1, i[3] ? 16 : 32, i[3] ? 12 : 24);
         rx_chk(v, ((i[2] && i[0] != (^v ^ i[1])) ? 8'h84 : 8'h80) |
            {6'h00, i[3], 1'b0});
      end
      $display("Parity and speed modes done");
      bus(1'b1, `ADDR_CTRL, 8'h31);
      chk("override", 8'h01, {7'h00, ovr});
      src.send(8'h81, 2'b00, 1'b0, 32, 32);
      rx_chk(8'h81, 8'h90);
      src.pulse(14);
      repeat (400) @(posedge clock);
      #1 chk("spike", 8'h00, {7'h00, rcf});
      for (i = 0; i < 3; i = i + 1)
         src.send({6'h18, i[1:0]}, 2'b00, 1'b1, 32, 24);
      for (i = 0; i < 3; i = i + 1)
         rx_chk({6'h18, i[1:0]}, 8'h80);
      @(posedge clock);
      #1 chk("drained", 8'h00, {7'h00, rcf});
      for (i = 0; i < 4; i = i + 1)
         src.send(8'h40 + i[7:0], 2'b00, 1'b1, 32, 32);
      rx_chk(8'h40, 8'h80);
      rx_chk(8'h41, 8'h80);
      rx_chk(8'h43, 8'h88);
      $display("Errors, spikes and queue done");
      src.send(8'h11, 2'b00, 1'b1, 32, 32);
      src.send(8'h22, 2'b00, 1'b1, 32, 32);
      fork
         src.send(8'hff, 2'b00, 1'b1, 32, 32);
         begin
            repeat (100) @(posedge clock);
            bus(1'b1, `ADDR_CTRL, 8'h30);
            repeat (2) @(posedge clock);
            #1 chk("disabled", 8'h00, {6'h00, ovr, rcf});
            bus(1'b1, `ADDR_CTRL, 8'h31);
         end
      join
      repeat (40) @(posedge clock);
      #1 chk("abandon", 8'h00, {7'h00, rcf});
      bus(1'b0, `ADDR_DATA, 8'h00);
      chk("empty", 8'h00, c);
      $display("Disable and flush done");
      stop_test;
   end
endmodule // tb
